// ==== hw/can_fifo_status_view.v ====
// fifo status view: overflow summary, per-fifo user address and interrupt over apb
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "can_fifo_status_view_defs.vh"
module can_fifo_status_view (
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [2:0] operating_mode_field,
  input wire [7:1] fifo_transmit_select,
  input wire [7:1] ovf_event,
  input wire [7:1] ovf_clear,
  input wire ptr_wr_en,
  input wire [2:0] ptr_wr_fifo,
  input wire ptr_wr_head,
  input wire [31:0] ptr_wr_addr,
  output wire config_mode,
  output wire irq
);

  // ****************************************************************
  // address decoding
  // ****************************************************************
  function is_ua;
    input [11:0] a;
    begin
      is_ua = (a[`UA_REGION_MSB:`UA_REGION_LSB] == `UA_REGION_TAG) &&
              (a[`UA_FIFO_MSB:`UA_FIFO_LSB] != 3'h0) && (a[1:0] == 2'h0);
    end
  endfunction

  function is_mapped;
    input [11:0] a;
    begin
      case (a)
        `RX_OVF_LOW_ADDR: is_mapped = 1'b1;
        `RX_OVF_HIGH_ADDR: is_mapped = 1'b1;
        `IRQ_STATUS_ADDR: is_mapped = 1'b1;
        `IRQ_CLEAR_ADDR: is_mapped = 1'b1;
        `IRQ_ENABLE_ADDR: is_mapped = 1'b1;
        `MODE_STATUS_ADDR: is_mapped = 1'b1;
        default: is_mapped = is_ua(a);
      endcase
    end
  endfunction

  // ****************************************************************
  // bus phases
  // ****************************************************************
  wire setup_phase;
  wire access_phase;
  wire ua_read;
  wire ua_launch;
  wire ua_wait;
  wire done;
  wire wr_done;
  reg wait_reg;
  reg wait_next;
  reg [31:0] prdata_reg;
  reg pslverr_reg;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign ua_read = is_ua(paddr) & ~pwrite;
  assign ua_launch = setup_phase & ua_read;
  // first access cycle of a user address read waits for the pointer store
  assign ua_wait = access_phase & ua_read & ~wait_reg;
  assign pready = ~ua_wait;
  assign done = access_phase & pready;
  assign wr_done = done & pwrite & ~pslverr_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  always @* begin
    wait_next = wait_reg;
    if (ua_wait) begin
      wait_next = 1'b1;
    end else if (done) begin
      wait_next = 1'b0;
    end
  end

  // ****************************************************************
  // operating mode
  // ****************************************************************
  assign config_mode = (operating_mode_field == `OPMODE_CONFIG);

  // ****************************************************************
  // overflow summary flags
  // ****************************************************************
  reg [7:0] ovf_reg;
  wire [7:0] ovf_next;

  // bit 0 has no fifo and stays zero
  assign ovf_next[0] = 1'b0;

  genvar g;
  generate
    for (g = `FIFO_FIRST; g <= `FIFO_LAST; g = g + 1) begin : ovf_bits
      // the fifo's own clear strobe drops the flag; a new overflow in the
      // same cycle wins so no event is lost
      assign ovf_next[g] = ovf_event[g] | (ovf_reg[g] & ~ovf_clear[g]);
    end
  endgenerate

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovf_reg <= `RX_OVF_RESET;
    end else begin
      ovf_reg <= ovf_next;
    end
  end

  // ****************************************************************
  // interrupt status, clear and enable
  // ****************************************************************
  reg [8:0] irq_status_reg;
  reg [8:0] irq_status_next;
  reg [8:0] irq_enable_reg;
  reg [8:0] irq_enable_next;
  wire [8:0] irq_set;
  wire [8:0] irq_clr;
  wire cfg_read_event;

  // a user address read in configuration mode may return a stale pointer
  assign cfg_read_event = ua_launch & config_mode;
  assign irq_set = {cfg_read_event, ovf_event, 1'b0};
  assign irq_clr = (wr_done && paddr == `IRQ_CLEAR_ADDR) ? pwdata[8:0] : 9'h000;

  always @* begin
    irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;
    irq_status_next[0] = 1'b0;
    irq_enable_next = irq_enable_reg;
    if (wr_done && paddr == `IRQ_ENABLE_ADDR) begin
      irq_enable_next = pwdata[8:0];
      irq_enable_next[0] = 1'b0;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_status_reg <= `IRQ_STATUS_RESET;
      irq_enable_reg <= `IRQ_ENABLE_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_enable_reg <= irq_enable_next;
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  // ****************************************************************
  // user address store
  // ****************************************************************
  wire [2:0] rd_fifo;
  wire [3:0] rd_index;
  wire [3:0] wr_index;
  wire [31:0] ptr_data;
  reg ua_half_reg;

  assign rd_fifo = paddr[`UA_FIFO_MSB:`UA_FIFO_LSB];
  // transmit fifo: head, where the next message goes; receive: tail
  assign rd_index = {rd_fifo, fifo_transmit_select[rd_fifo]};
  assign wr_index = {ptr_wr_fifo, ptr_wr_head};

  fifo_pointer_store store (
    .ref_clk(ref_clk),
    .wr_en(ptr_wr_en),
    .wr_index(wr_index),
    .wr_data(ptr_wr_addr),
    .rd_en(ua_launch),
    .rd_index(rd_index),
    .rd_data(ptr_data)
  );

  // ****************************************************************
  // read data
  // ****************************************************************
  reg [31:0] read_mux;

  // reads only sample state, except that a user address read in configuration mode sets interrupt status bit 8
  always @* begin
    read_mux = `UNMAPPED_READ;
    case (paddr)
      `RX_OVF_LOW_ADDR: read_mux = {24'h00_0000, ovf_reg};
      `RX_OVF_HIGH_ADDR: read_mux = `UNMAPPED_READ;
      `IRQ_STATUS_ADDR: read_mux = {23'h00_0000, irq_status_reg};
      `IRQ_ENABLE_ADDR: read_mux = {23'h00_0000, irq_enable_reg};
      `MODE_STATUS_ADDR: read_mux = {28'h000_0000, operating_mode_field, config_mode};
      default: read_mux = `UNMAPPED_READ;
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= `PRDATA_RESET;
      pslverr_reg <= 1'b0;
      wait_reg <= 1'b0;
      ua_half_reg <= 1'b0;
    end else begin
      wait_reg <= wait_next;
      if (setup_phase) begin
        prdata_reg <= read_mux;
        pslverr_reg <= ~is_mapped(paddr);
        ua_half_reg <= paddr[`UA_HALF_BIT];
      end else if (ua_wait) begin
        // word 0 of the pair carries bits 31:16, word 1 bits 15:0
        if (ua_half_reg) begin
          prdata_reg <= {16'h0000, ptr_data[15:0]};
        end else begin
          prdata_reg <= {16'h0000, ptr_data[31:16]};
        end
      end
    end
  end

  // writes to the summary, status, mode and user address words store nothing

endmodule

// ==== hw/can_fifo_status_view_defs.vh ====
// register offsets, field positions, reset values and timing counts of the fifo status view
//
// Operation
// - overflow pending flags, fifos 1-7, bits 7:1
// - flags read 0 when idle, reset 0
// - summary read-only; clear in fifo register
// - summary bits 31:8 hold no flag
// - low summary bit 0 reads zero
// - 32-bit read-only user address per fifo
// - transmit fifo returns head location
// - receive fifo returns tail location
// - operating mode value 100 means configuration
`ifndef CAN_FIFO_STATUS_VIEW_DEFS_VH
`define CAN_FIFO_STATUS_VIEW_DEFS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define RX_OVF_LOW_ADDR 12'h000
`define RX_OVF_HIGH_ADDR 12'h004
`define IRQ_STATUS_ADDR 12'h008
`define IRQ_CLEAR_ADDR 12'h00C
`define IRQ_ENABLE_ADDR 12'h010
`define MODE_STATUS_ADDR 12'h014
// user address window: 0x40 + 8 * fifo, high half at +0, low half at +4
`define UA_REGION_TAG 6'h01
`define UA_REGION_MSB 11
`define UA_REGION_LSB 6
`define UA_FIFO_MSB 5
`define UA_FIFO_LSB 3
`define UA_HALF_BIT 2

// ****************************************************************
// fields
// ****************************************************************
`define FIFO_FIRST 1
`define FIFO_LAST 7
`define OVF_FLAG_MSB 7
`define CFG_READ_EVENT_BIT 8
`define IRQ_MSB 8
`define MODE_CFG_BIT 0
`define MODE_FIELD_LSB 1
`define MODE_FIELD_MSB 3
`define OPMODE_CONFIG 3'h4

// ****************************************************************
// reset values
// ****************************************************************
`define RX_OVF_RESET 8'h00
`define IRQ_STATUS_RESET 9'h000
`define IRQ_ENABLE_RESET 9'h000
`define PRDATA_RESET 32'h0000_0000
`define UNMAPPED_READ 32'h0000_0000

// ****************************************************************
// timing: wait states of a user address read
// ****************************************************************
`define UA_READ_WAIT 1

`endif

// ==== hw/fifo_pointer_store.v ====
// pointer store: head and tail user address of every fifo, registered read
`timescale 1ns/10ps
module fifo_pointer_store (
  input wire ref_clk,
  input wire wr_en,
  input wire [3:0] wr_index,
  input wire [31:0] wr_data,
  input wire rd_en,
  input wire [3:0] rd_index,
  output reg [31:0] rd_data
);

  reg [31:0] mem [0:15];

  // no reset: the pointers power up unknown, as the user address does
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_index] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_index];
    end
  end

endmodule

// ==== testbench/can_fifo_status_view_monitor.sv ====
// assertion checker on the ports of the fifo status view
`timescale 1ns/10ps
module can_fifo_status_view_monitor (
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [2:0] operating_mode_field,
  input wire config_mode,
  input wire irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire done = psel && penable && pready;
  wire rd_done = done && !pwrite;
  // fifo 0 slot is unmapped, so it takes no wait state
  wire ua_setup = psel && !penable && !pwrite && paddr[11:6] == 6'h01 &&
    paddr[5:3] != 3'h0 && paddr[1:0] == 2'h0;
  AST_CFG_MODE: assert property (config_mode == (operating_mode_field == 3'h4))
    else $error("config_mode wrong");
  AST_SUM_BIT0: assert property (rd_done && paddr == 12'h000 |-> !prdata[0])
    else $error("summary bit 0 set");
  AST_SUM_UPPER: assert property (rd_done && paddr == 12'h000 |-> prdata[31:8] == 24'h0)
    else $error("summary upper bits set");
  AST_SUM_HIGH: assert property (rd_done && paddr == 12'h004 |-> prdata == 32'h0)
    else $error("summary high not zero");
  AST_UA_WAIT: assert property (ua_setup |=> !pready ##1 pready)
    else $error("user address wait wrong");
  AST_UA_UPPER: assert property (rd_done && ua_setup == 1'b0 && paddr[11:6] == 6'h01
    && !pslverr |-> prdata[31:16] == 16'h0)
    else $error("user address upper bits set");
  AST_BAD_ADDR: assert property (done && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  AST_ERR_DATA: assert property (rd_done && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  AST_IRQ_RST: assert property ($fell(rst) |-> !irq)
    else $error("irq high after reset");
  cover property (ua_setup);
  cover property (rd_done && paddr == 12'h000 && prdata[7:1] != 7'h0);
  cover property (irq);
endmodule
bind can_fifo_status_view can_fifo_status_view_monitor u_mon (.ref_clk, .rst, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .operating_mode_field,
  .config_mode, .irq);

// ==== testbench/can_engine_model.sv ====
// behavioural can engine side: overflow pulses, flag clears, pointer updates
`timescale 1ns/10ps
module can_engine_model (
  input wire ref_clk,
  output logic [7:1] ovf_event,
  output logic [7:1] ovf_clear,
  output logic ptr_wr_en,
  output logic [2:0] ptr_wr_fifo,
  output logic ptr_wr_head,
  output logic [31:0] ptr_wr_addr
);
  initial begin
    ovf_event = 7'h0;
    ovf_clear = 7'h0;
    ptr_wr_en = 1'b0;
    ptr_wr_fifo = 3'h0;
    ptr_wr_head = 1'b0;
    ptr_wr_addr = 32'h0;
  end
  task automatic overflow(input logic [2:0] n);
    @(posedge ref_clk);
    ovf_event[n] <= 1'b1;
    @(posedge ref_clk);
    ovf_event <= 7'h0;
  endtask
  task automatic clear(input logic [2:0] n);
    @(posedge ref_clk);
    ovf_clear[n] <= 1'b1;
    @(posedge ref_clk);
    ovf_clear <= 7'h0;
  endtask
  task automatic put_ptr(input logic [2:0] f, input logic h, input logic [31:0] a);
    @(posedge ref_clk);
    ptr_wr_en <= 1'b1;
    ptr_wr_fifo <= f;
    ptr_wr_head <= h;
    ptr_wr_addr <= a;
    @(posedge ref_clk);
    ptr_wr_en <= 1'b0;
    // stale data must not look valid once the strobe drops
    ptr_wr_addr <= ~a;
  endtask
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench of the fifo status view
`timescale 1ns/10ps
module testbench;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, config_mode, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, e, ptr_wr_addr;
  logic [2:0] operating_mode_field, ptr_wr_fifo;
  logic [7:1] fifo_transmit_select, ovf_event, ovf_clear;
  logic ptr_wr_en, ptr_wr_head;
  int bad_count = 0;
  int tests_run = 0;
  can_fifo_status_view u_can_fifo_status_view (.ref_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .operating_mode_field,
    .fifo_transmit_select, .ovf_event, .ovf_clear, .ptr_wr_en, .ptr_wr_fifo,
    .ptr_wr_head, .ptr_wr_addr, .config_mode, .irq);
  can_engine_model u_can_engine_model (.ref_clk, .ovf_event, .ovf_clear, .ptr_wr_en,
    .ptr_wr_fifo, .ptr_wr_head, .ptr_wr_addr);
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    tests_run++;
    if (got !== x) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, got);
    end
  endtask
  // pready, prdata and pslverr are taken at the rising edge that ends the access;
  // the request stands until then, and the task returns mid-cycle so outputs settle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) bad_count++;
    @(negedge ref_clk);
  endtask
  task t_reset;
    apb(1'b0, 12'h000, 32'h0);
    chk("sum_low", 32'h0, rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("sum_high", 32'h0, rd);
  endtask
  task t_ovf;
    for (int i = 1; i <= 7; i++) u_can_engine_model.overflow(i[2:0]);
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    apb(1'b0, 12'h000, 32'h0);
    chk("sum_low", 32'h0000_00FE, rd);
    u_can_engine_model.clear(3'h3);
    apb(1'b0, 12'h000, 32'h0);
    chk("sum_low", 32'h0000_00F6, rd);
  endtask
  task t_irq;
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h010, 32'h0000_0004);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h00C, 32'h0000_01FE);
    chk("irq", 32'h0, {31'h0, irq});
  endtask
  task t_ptr;
    fifo_transmit_select <= 7'b1010101;
    for (int f = 1; f <= 7; f++) begin
      u_can_engine_model.put_ptr(f[2:0], 1'b1, 32'hA5A5_0000 + f);
      u_can_engine_model.put_ptr(f[2:0], 1'b0, 32'h5A5A_0000 + f);
    end
    for (int f = 1; f <= 7; f++) begin
      e = (f % 2 == 1) ? 32'hA5A5_0000 + f : 32'h5A5A_0000 + f;
      apb(1'b0, 12'h040 + 12'(8 * f), 32'h0);
      chk("ua_high", {16'h0, e[31:16]}, rd);
      apb(1'b0, 12'h044 + 12'(8 * f), 32'h0);
      chk("ua_low", {16'h0, e[15:0]}, rd);
    end
    apb(1'b0, 12'h042, 32'h0);
    chk("err", 32'h1, {31'h0, err});
  endtask
  task t_cfg;
    operating_mode_field <= 3'h4;
    apb(1'b0, 12'h014, 32'h0);
    chk("mode", 32'h0000_0009, rd);
    apb(1'b1, 12'h010, 32'h0000_0100);
    apb(1'b0, 12'h048, 32'h0);
    chk("irq", 32'h1, {31'h0, irq});
    operating_mode_field <= 3'h0;
  endtask
  task give_verdict;
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    operating_mode_field = 3'h0;
    fifo_transmit_select = 7'h0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_ovf;
    t_irq;
    t_ptr;
    t_cfg;
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    give_verdict;
  end
endmodule
